// ---- hw/vmon_cfg_pkg.sv ----
package vmon_cfg_pkg;

  // register offsets on the serial control port
  localparam logic [7:0] RAIL3_WINDOW_OFS  = 8'h1A;
  localparam logic [7:0] RAIL4_WINDOW_OFS  = 8'h1B;
  localparam logic [7:0] MON_CTRL_OFS      = 8'h2B;
  localparam logic [7:0] SUPPLY_WINDOW_OFS = 8'h2C;
  localparam logic [7:0] PIN1_WINDOW_OFS   = 8'h2D;
  localparam logic [7:0] REG_RESET_VAL     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

  // window register fields
  localparam int LOW_CODE_MSB  = 5;
  localparam int LOW_CODE_LSB  = 3;
  localparam int HIGH_CODE_MSB = 2;
  localparam int HIGH_CODE_LSB = 0;
  localparam int NOMINAL_BIT   = 6;

  // monitor control fields
  localparam int FILT_SEL_MSB  = 7;
  localparam int FILT_SEL_LSB  = 5;
  localparam int PIN2_RV_BIT   = 4;
  localparam int PIN2_EN_BIT   = 3;
  localparam int PIN1_RV_BIT   = 2;
  localparam int PIN1_EN_BIT   = 1;
  localparam int SUPPLY_EN_BIT = 0;
  localparam logic [2:0] FILT_SEL_SHORT = 3'h0;

  // deglitch times; least times round up to whole cycles
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FILT_SHORT_NS  = 4000;
  localparam int FILT_LONG_NS   = 20000;
  localparam int FILT_SHORT_CYC = (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_LONG_CYC  = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W     = 11;

  localparam int NUM_MON = 10;

  typedef struct packed {
    logic [7:0] pin1_window;
    logic [7:0] supply_window;
    logic [7:0] mon_ctrl;
    logic [7:0] rail4_window;
    logic [7:0] rail3_window;
  } cfg_t;

  // one bit per comparator; bit 0 is rail_three low
  typedef struct packed {
    logic pin2_high;
    logic pin2_low;
    logic pin1_high;
    logic pin1_low;
    logic supply_high;
    logic supply_low;
    logic rail4_high;
    logic rail4_low;
    logic rail3_high;
    logic rail3_low;
  } mon_t;

endpackage

// ---- hw/vmon_cfg_regs.sv ----
// How it works
// - rail_three window register keeps its low margin code in bits 5:3 (-3% .. -10%).
// - rail_three window register keeps its high margin code in bits 2:0 (+3% .. +10%).
// - rail_four window register uses the same layout, low code 5:3 and high code 2:0.
// - control bits 7:5 pick the deglitch time of every monitor, 0 is 4 us and 1 is 20 us.
// - control bit 4 stores the residual check enable of the second monitor pin; no logic here reads it.
// - control bit 3 enables both comparators of the second monitor pin.
// - control bit 2 stores the residual check enable of the first monitor pin; no logic here reads it.
// - control bit 1 enables both comparators of the first monitor pin.
// - control bit 0 enables both comparators of the analog supply input.
// - supply window bit 6 picks the nominal supply level, 0 is 3.3 V and 1 is 5.0 V.
// - supply window bits 5:3 hold the supply low margin code.
// - supply window bits 2:0 hold the supply high margin code.
// - every field takes its power-up value from the non-volatile image, reset being zero.
// - the windows sit at 0x1A, 0x1B, 0x2C, 0x2D and the control at 0x2B, all reset to 0x00.
// - reserved bits of the window registers are plain read/write storage reset to zero.
`timescale 1ns/1ps
module vmon_cfg_regs
  import vmon_cfg_pkg::*;
#(
  parameter int FILT_SHORT = vmon_cfg_pkg::FILT_SHORT_CYC,
  parameter int FILT_LONG  = vmon_cfg_pkg::FILT_LONG_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 nvm_load,
  input  wire vmon_cfg_pkg::cfg_t   nvm_image,
  input  wire vmon_cfg_pkg::mon_t   cmp_raw,
  output vmon_cfg_pkg::cfg_t        cfg_q,
  output vmon_cfg_pkg::mon_t        mon_fault_q
);
  import vmon_cfg_pkg::*;

  localparam logic [FILT_CNT_W-1:0] SHORT_LIM = FILT_CNT_W'(FILT_SHORT);
  localparam logic [FILT_CNT_W-1:0] LONG_LIM  = FILT_CNT_W'(FILT_LONG);

  cfg_t        cfg_d;
  logic [7:0]  rdata_d;
  mon_t        sync1_q;
  mon_t        sync2_q;

  wire sel_rail3  = (reg_addr == RAIL3_WINDOW_OFS);
  wire sel_rail4  = (reg_addr == RAIL4_WINDOW_OFS);
  wire sel_ctrl   = (reg_addr == MON_CTRL_OFS);
  wire sel_supply = (reg_addr == SUPPLY_WINDOW_OFS);
  wire sel_pin1   = (reg_addr == PIN1_WINDOW_OFS);
  wire wr_ok      = reg_wr && !nvm_load;

  // named views of the stored fields
  wire [2:0] rail3_low_margin_code  = cfg_q.rail3_window[LOW_CODE_MSB:LOW_CODE_LSB];
  wire [2:0] rail3_high_margin_code = cfg_q.rail3_window[HIGH_CODE_MSB:HIGH_CODE_LSB];
  wire [2:0] rail4_low_margin_code  = cfg_q.rail4_window[LOW_CODE_MSB:LOW_CODE_LSB];
  wire [2:0] rail4_high_margin_code = cfg_q.rail4_window[HIGH_CODE_MSB:HIGH_CODE_LSB];
  wire [2:0] monitor_filter_time_select = cfg_q.mon_ctrl[FILT_SEL_MSB:FILT_SEL_LSB];
  wire pin2_residual_check_enable  = cfg_q.mon_ctrl[PIN2_RV_BIT];
  wire pin2_comparator_enable      = cfg_q.mon_ctrl[PIN2_EN_BIT];
  wire pin1_residual_check_enable  = cfg_q.mon_ctrl[PIN1_RV_BIT];
  wire pin1_comparator_enable      = cfg_q.mon_ctrl[PIN1_EN_BIT];
  wire supply_comparator_enable    = cfg_q.mon_ctrl[SUPPLY_EN_BIT];
  wire supply_nominal_level_select = cfg_q.supply_window[NOMINAL_BIT];
  wire [2:0] supply_low_margin_code  = cfg_q.supply_window[LOW_CODE_MSB:LOW_CODE_LSB];
  wire [2:0] supply_high_margin_code = cfg_q.supply_window[HIGH_CODE_MSB:HIGH_CODE_LSB];

  // codes 2..7 are undefined; anything but 0 takes the longer, safer time
  wire short_filt = (monitor_filter_time_select == FILT_SEL_SHORT);
  wire [FILT_CNT_W-1:0] filt_limit = short_filt ? SHORT_LIM : LONG_LIM;

  // rail monitors have no enable in this bank and always run
  wire [NUM_MON-1:0] mon_en = {{2{pin2_comparator_enable}},
                               {2{pin1_comparator_enable}},
                               {2{supply_comparator_enable}},
                               4'hF};

  // nvm image beats a software write in the same cycle; full bytes are stored,
  // so reserved bits keep what was written
  assign cfg_d.rail3_window  = nvm_load ? nvm_image.rail3_window :
                               (wr_ok && sel_rail3) ? reg_wdata : cfg_q.rail3_window;
  assign cfg_d.rail4_window  = nvm_load ? nvm_image.rail4_window :
                               (wr_ok && sel_rail4) ? reg_wdata : cfg_q.rail4_window;
  assign cfg_d.mon_ctrl      = nvm_load ? nvm_image.mon_ctrl :
                               (wr_ok && sel_ctrl) ? reg_wdata : cfg_q.mon_ctrl;
  assign cfg_d.supply_window = nvm_load ? nvm_image.supply_window :
                               (wr_ok && sel_supply) ? reg_wdata : cfg_q.supply_window;
  assign cfg_d.pin1_window   = nvm_load ? nvm_image.pin1_window :
                               (wr_ok && sel_pin1) ? reg_wdata : cfg_q.pin1_window;

  assign rdata_d = sel_rail3  ? cfg_q.rail3_window :
                   sel_rail4  ? cfg_q.rail4_window :
                   sel_ctrl   ? cfg_q.mon_ctrl :
                   sel_supply ? cfg_q.supply_window :
                   sel_pin1   ? cfg_q.pin1_window : UNMAPPED_READ_VAL;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q      <= {5{REG_RESET_VAL}};
      reg_rdata  <= REG_RESET_VAL;
      reg_rvalid <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      reg_rdata  <= reg_rd ? rdata_d : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // comparator outputs are analog and asynchronous
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= cmp_raw;
      sync2_q <= sync1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MON; gi++) begin : g_filt
      vmon_glitch_filter #(
        .CNT_W (FILT_CNT_W)
      ) u_filt (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .enable   (mon_en[gi]),
        .cond_in  (sync2_q[gi]),
        .limit    (filt_limit),
        .fault_q  (mon_fault_q[gi])
      );
    end
  endgenerate

  // helper: consecutive cycles that rail_three low has been seen high
  logic [12:0] persist_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      persist_q <= '0;
    end else begin
      persist_q <= sync2_q.rail3_low ? ((persist_q == 13'h1FFF) ? persist_q
                                        : persist_q + 13'h0001) : 13'h0000;
    end
  end

  // helper: address hits one of the five stored registers, spelled out apart from the decoder
  wire addr_mapped = (reg_addr == 8'h1A) || (reg_addr == 8'h1B) || (reg_addr == 8'h2B)
                     || (reg_addr == 8'h2C) || (reg_addr == 8'h2D);

  a_rail3_low_code: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h1A)
      |=> (rail3_low_margin_code == $past(reg_wdata[5:3])))
    else $error("rail3 low code not stored");

  a_rail3_high_code: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h1A)
      |=> (rail3_high_margin_code == $past(reg_wdata[2:0])))
    else $error("rail3 high code not stored");

  a_rail4_codes: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h1B)
      |=> (rail4_low_margin_code == $past(reg_wdata[5:3]))
          && (rail4_high_margin_code == $past(reg_wdata[2:0])))
    else $error("rail4 codes not stored");

  a_filter_time_exact: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(mon_fault_q.rail3_low) && $stable(filt_limit))
      |-> (persist_q == {2'b00, filt_limit}))
    else $error("fault reported before or after the deglitch time");

  // works for any short limit, not only the 400-cycle default
  a_short_no_early: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (short_filt && $rose(mon_fault_q.rail3_low))
      |-> (persist_q >= {2'b00, SHORT_LIM}))
    else $error("short deglitch fired too early");

  a_ctrl_residual: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h2B)
      |=> (pin2_residual_check_enable == $past(reg_wdata[4]))
          && (pin1_residual_check_enable == $past(reg_wdata[2])))
    else $error("residual check enables not stored");

  a_pin2_off_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !pin2_comparator_enable |=> !mon_fault_q.pin2_low && !mon_fault_q.pin2_high)
    else $error("pin2 fault while disabled");

  a_pin1_off_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !pin1_comparator_enable |=> !mon_fault_q.pin1_low && !mon_fault_q.pin1_high)
    else $error("pin1 fault while disabled");

  a_supply_off_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !supply_comparator_enable |=> !mon_fault_q.supply_low && !mon_fault_q.supply_high)
    else $error("supply fault while disabled");

  a_supply_window_wr: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h2C)
      |=> (supply_nominal_level_select == $past(reg_wdata[6]))
          && (supply_low_margin_code == $past(reg_wdata[5:3]))
          && (supply_high_margin_code == $past(reg_wdata[2:0])))
    else $error("supply window not stored");

  a_nvm_default: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    nvm_load |=> (cfg_q == $past(nvm_image)))
    else $error("nvm image not loaded");

  a_read_map: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h2B)
      |=> reg_rvalid && (reg_rdata == $past(cfg_q.mon_ctrl)))
    else $error("control readback wrong");

  a_reserved_keep: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h1B) ##1 (reg_rd && reg_addr == 8'h1B)
      |=> (reg_rdata[7:6] == $past(reg_wdata[7:6], 2)))
    else $error("reserved bits not kept");

  a_rvalid_pulse: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (reg_rvalid == $past(reg_rd)))
    else $error("read valid not one cycle after the strobe");

  a_unmapped_read: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && !addr_mapped) |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  a_unmapped_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && !addr_mapped) |=> $stable(cfg_q))
    else $error("unmapped write changed a register");

  a_rdata_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_rail3_read_map: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h1A) |=> (reg_rdata == $past(cfg_q.rail3_window)))
    else $error("rail3 readback wrong");

  a_rail4_read_map: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h1B) |=> (reg_rdata == $past(cfg_q.rail4_window)))
    else $error("rail4 readback wrong");

  a_supply_read_map: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h2C) |=> (reg_rdata == $past(cfg_q.supply_window)))
    else $error("supply readback wrong");

  a_supply_reserved_bit: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h2C)
      |=> (cfg_q.supply_window[7] == $past(reg_wdata[7])))
    else $error("supply reserved bit not kept");

  a_ctrl_fields_wr: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && !nvm_load && reg_addr == 8'h2B)
      |=> (monitor_filter_time_select == $past(reg_wdata[7:5]))
          && (pin2_comparator_enable == $past(reg_wdata[3]))
          && (pin1_comparator_enable == $past(reg_wdata[1]))
          && (supply_comparator_enable == $past(reg_wdata[0])))
    else $error("control fields not stored");

  a_drop_clears_fault: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !sync2_q.rail3_low |=> !mon_fault_q.rail3_low)
    else $error("fault outlived its comparator level");

  a_fault_needs_level: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    mon_fault_q.rail4_high |-> $past(sync2_q.rail4_high))
    else $error("fault without a comparator level");

  c_long_fault: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    !short_filt ##1 $rose(mon_fault_q.rail4_high));

  c_pin2_fault: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(mon_fault_q.pin2_low));

  c_nvm_then_read: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    nvm_load ##1 (reg_rd && reg_addr == 8'h2C));

  c_glitch_drop: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(sync2_q.rail3_high) && !mon_fault_q.rail3_high);

endmodule // vmon_cfg_regs

// ---- hw/vmon_glitch_filter.sv ----
`timescale 1ns/1ps
module vmon_glitch_filter #(
  parameter int CNT_W = 11
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             enable,
  input  wire logic             cond_in,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  fault_q
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             fault_d;
  wire              run  = enable && cond_in;
  wire              done = (count_q >= limit - CNT_W'(1));

  // a drop of the condition restarts the interval; a fault clears at once
  assign count_d = !run ? '0 : (done ? count_q : count_q + CNT_W'(1));
  assign fault_d = run && (fault_q || done);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
      fault_q <= 1'b0;
    end else begin
      count_q <= count_d;
      fault_q <= fault_d;
    end
  end

endmodule // vmon_glitch_filter

// ---- tb/vmon_cfg_regs_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module vmon_cfg_regs_tb;
  import vmon_cfg_pkg::*;
  // short filters keep the run brief; expectations follow from these two values
  localparam int SH = 4;
  localparam int LG = 10;
  logic       core_clk;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       nvm_load;
  cfg_t       nvm_image;
  mon_t       cmp_raw;
  cfg_t       cfg_q;
  mon_t       mon_fault_q;
  int         n_mismatch;
  int         check_count;
  logic [7:0] ofs [5];

  vmon_cfg_regs #(.FILT_SHORT(SH), .FILT_LONG(LG)) dut (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .reg_rvalid  (reg_rvalid),
    .nvm_load    (nvm_load),
    .nvm_image   (nvm_image),
    .cmp_raw     (cmp_raw),
    .cfg_q       (cfg_q),
    .mon_fault_q (mon_fault_q)
  );

  always #5 core_clk = ~core_clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // callers enter just after a rising edge and leave the same way
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge core_clk); #1;
    reg_wr = 1'b0;
    // an idle edge keeps a following write from raising the strobe in the same step
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk); #1;
    reg_rd = 1'b0;
    `CHK({nm, " rvalid"}, 1'b1, reg_rvalid)
    `CHK(nm, e, reg_rdata)
    @(posedge core_clk); #1;
    `CHK({nm, " rvalid drop"}, 1'b0, reg_rvalid)
  endtask

  // n counts edges from the drive until the fault shows: two sync stages plus the filter
  task automatic meas(input int b, input int lim, input string nm);
    int n;
    n = 0;
    cmp_raw[b] = 1'b1;
    while (mon_fault_q[b] !== 1'b1 && n < 3000) begin
      @(posedge core_clk); #1;
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      end_of_test;
    end
    `CHK(nm, lim + 2, n)
    cmp_raw[b] = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({nm, " clear"}, 1'b0, mon_fault_q[b])
  endtask

  task automatic t_regs;
    cfg_t exp_cfg;
    for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00, "reset value");
    for (int i = 0; i < 5; i++) wr(ofs[i], 8'hC1 + 8'(i * 17));
    exp_cfg = {8'h05, 8'hF4, 8'hE3, 8'hD2, 8'hC1};
    `CHK("cfg after writes", exp_cfg, cfg_q)
    wr(8'h2A, 8'hFF);
    `CHK("cfg after unmapped write", exp_cfg, cfg_q)
    rd(8'h2A, UNMAPPED_READ_VAL, "unmapped read");
    for (int i = 0; i < 5; i++) rd(ofs[i], 8'hC1 + 8'(i * 17), "readback");
    // write then read on the next edge, by hand, so the read follows directly
    reg_addr  = RAIL4_WINDOW_OFS;
    reg_wdata = 8'hC0;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    rd(RAIL4_WINDOW_OFS, 8'hC0, "reserved bits");
    wr(RAIL3_WINDOW_OFS, 8'h3F);
    `CHK("rail3 low code", 3'h7, cfg_q.rail3_window[5:3])
    `CHK("rail3 high code", 3'h7, cfg_q.rail3_window[2:0])
    $display("test registers done");
  endtask

  task automatic t_nvm;
    nvm_image = 40'h5A_C3_1E_87_69;
    nvm_load  = 1'b1;
    wr(MON_CTRL_OFS, 8'h00);
    nvm_load = 1'b0;
    `CHK("nvm image", 40'h5A_C3_1E_87_69, cfg_q)
    rd(SUPPLY_WINDOW_OFS, 8'hC3, "supply after nvm");
    $display("test nvm load done");
  endtask

  task automatic t_filter;
    logic [2:0] codes [3];
    codes = '{3'h0, 3'h1, 3'h7};
    for (int i = 0; i < 3; i++) begin
      wr(MON_CTRL_OFS, {codes[i], 5'h00});
      meas(0, (codes[i] == 3'h0) ? SH : LG, "rail3 low delay");
      meas(3, (codes[i] == 3'h0) ? SH : LG, "rail4 high delay");
    end
    wr(MON_CTRL_OFS, 8'h00);
    for (int b = 1; b < 3; b++) meas(b, SH, "rail3 high rail4 low delay");
    for (int k = 0; k < 4; k++) begin
      cmp_raw[1] = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      cmp_raw[1] = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("glitch passed", 1'b0, mon_fault_q[1])
    end
    $display("test filter done");
  endtask

  task automatic t_enable;
    wr(MON_CTRL_OFS, 8'h14);
    `CHK("residual enables", 2'b11, {cfg_q.mon_ctrl[4], cfg_q.mon_ctrl[2]})
    for (int b = 4; b < 10; b++) begin
      cmp_raw[b] = 1'b1;
      repeat (SH + 6) @(posedge core_clk);
      #1;
      `CHK("disabled fault", 1'b0, mon_fault_q[b])
      cmp_raw[b] = 1'b0;
    end
    wr(MON_CTRL_OFS, 8'h0B);
    for (int b = 4; b < 10; b++) meas(b, SH, "enabled delay");
    $display("test enables done");
  endtask

  initial begin
    core_clk    = 1'b0;
    sys_rst     = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    nvm_load    = 1'b0;
    nvm_image   = '0;
    cmp_raw     = '0;
    n_mismatch  = 0;
    check_count = 0;
    ofs = '{RAIL3_WINDOW_OFS, RAIL4_WINDOW_OFS, MON_CTRL_OFS, SUPPLY_WINDOW_OFS,
            PIN1_WINDOW_OFS};
    repeat (16) @(posedge core_clk);
    #1;
    `CHK("cfg in reset", 40'h0, cfg_q)
    sys_rst = 1'b0;
    t_regs;
    t_nvm;
    t_filter;
    t_enable;
    end_of_test;
  end
endmodule // vmon_cfg_regs_tb
